// [design/sfk_modem_core.v]
/*
 * Timing and transmit core of a mains-synchronised tone modem: digital
 * loop locking a tick clock to mains rising edges, frame timing strobes,
 * tone synthesizer and sigma-delta output.
 * Assumes a 200 MHz clock, an asynchronous mains comparator input and a
 * simple register port (read data valid the cycle after the read strobe).
 */
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "sfk_regs.vh"

// Notes on behaviour
// - tick clock runs eight ticks per bit
// - config bit 0 picks 50 or 60 Hz
// - config bits 2:1 pick 6..48 bits/period
// - tick rates eight times bit rates
// - loop reacts only to rising mains edges
// - missing edges: loop timers repeat last period, ticks continue
// - ticks phase locked to mains rising edge
// - trim advances ticks by value times 13us
// - tick count kept across mode switches
// - bit strobe at counts multiple of 8
// - byte strobe at counts multiple of 64
// - frame strobe at count zero
// - early byte strobe eight ticks before byte
// - early frame strobe eight ticks before frame
// - frame lead window drives sync pin
// - mode flag high transmits, low receives
// - transmit byte register feeds modulator bits
// - space tone for 0, mark for 1
// - tone equals step times 3MHz over 2^18
// - accumulator starts at zero, phase continuous
// - finish current sine period before stopping
// - sigma-delta turns samples into pulse stream
module sfk_modem_core #(
    parameter NOM_PERIOD_50 = `SFK_NOM_PERIOD_50,
    parameter NOM_PERIOD_60 = `SFK_NOM_PERIOD_60
) (
    input wire mclk_i,
    input wire rstn_i,
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    input wire mains_sense_pin_i,
    output reg chip_tick_o,
    output reg bit_strobe_o,
    output reg byte_strobe_o,
    output reg frame_strobe_o,
    output reg early_byte_strobe_o,
    output reg early_frame_strobe_o,
    output reg frame_lead_o,
    output reg sync_output_pin_o,
    output reg tx_active_o,
    output reg pdm_o
);
    // parameters arrive as 32-bit integers; the cut to the counter
    // widths is made here on purpose
    localparam [31:0] NOM50_W = NOM_PERIOD_50;
    localparam [31:0] NOM60_W = NOM_PERIOD_60;
    localparam [31:0] TRIM_STEP_W = `SFK_TRIM_STEP_CYC;
    localparam [31:0] DDS_NUM_W = `SFK_DDS_NUM;
    localparam [31:0] DDS_DEN_W = `SFK_DDS_DEN;
    localparam [23:0] NOM50 = NOM50_W[23:0];
    localparam [23:0] NOM60 = NOM60_W[23:0];
    localparam [11:0] TRIM_STEP = TRIM_STEP_W[11:0];
    localparam [7:0] DDS_NUM = DDS_NUM_W[7:0];
    localparam [7:0] DDS_DEN = DDS_DEN_W[7:0];
    localparam [17:0] STEP_ZERO = 18'h0_0000;

    // registers
    // tone steps are 16 bits wide; upper write data bits are dropped
    reg [7:0] modem_config;
    reg [7:0] zero_cross_phase_trim;
    reg [7:0] transmit_byte;
    reg [15:0] mark_tone_step;
    reg [15:0] space_tone_step;
    reg [7:0] modem_ctrl;
    wire transmit_mode_flag = modem_ctrl[`SFK_CTRL_TXMODE_BIT];

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            modem_config <= `SFK_RST_CONFIG;
            zero_cross_phase_trim <= `SFK_RST_TRIM;
            transmit_byte <= `SFK_RST_TXBYTE;
            mark_tone_step <= `SFK_RST_STEP;
            space_tone_step <= `SFK_RST_STEP;
            modem_ctrl <= `SFK_RST_CTRL;
        end else if (wr_i) begin
            case (addr_i)
                `SFK_ADDR_CONFIG: modem_config <= wdata_i[7:0];
                `SFK_ADDR_TRIM: zero_cross_phase_trim <= wdata_i[7:0];
                `SFK_ADDR_TXBYTE: transmit_byte <= wdata_i[7:0];
                `SFK_ADDR_MARK: mark_tone_step <= wdata_i[15:0];
                `SFK_ADDR_SPACE: space_tone_step <= wdata_i[15:0];
                `SFK_ADDR_CTRL: modem_ctrl <= wdata_i[7:0];
                default: ;
            endcase
        end
    end

    // mains input: three flops, a change counts once stages 2 and 3 agree
    // stage 1 may go metastable; only stage 2 reads it
    reg zc_s1, zc_s2, zc_s3, zc_level;
    wire zc_rise = zc_s2 & zc_s3 & ~zc_level;
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            zc_s1 <= 1'b0;
            zc_s2 <= 1'b0;
            zc_s3 <= 1'b0;
            zc_level <= 1'b0;
        end else begin
            zc_s1 <= mains_sense_pin_i;
            zc_s2 <= zc_s1;
            zc_s3 <= zc_s2;
            if (zc_s2 == zc_s3) begin
                zc_level <= zc_s3;
            end
        end
    end

    // mains period tracking
    wire [23:0] nominal = modem_config[`SFK_CFG_MAINS_BIT] ? NOM60 : NOM50;
    reg [23:0] since_edge;
    reg [23:0] period;
    reg [23:0] virt_cnt;
    wire [19:0] adv_cyc = zero_cross_phase_trim * TRIM_STEP;
    wire [24:0] avg_sum = {1'b0, period} + {1'b0, since_edge};
    // rises less than a quarter nominal period after the last edge are not taken as edges
    wire edge_ok = zc_rise && (since_edge >= {2'b00, nominal[23:2]});
    // long gaps re-phase but do not drag the period estimate
    wire edge_fresh = since_edge <= {nominal[22:0], 1'b0};
    wire [23:0] new_period = edge_fresh ? avg_sum[24:1] : period;
    // a trim longer than the period is dropped rather than wrapped,
    // so a wild setting cannot place the edge in the wrong period
    wire [23:0] lead_load = (new_period > {4'h0, adv_cyc}) ?
        new_period - {4'h0, adv_cyc} : new_period;
    // the virtual edge is where the loop expects the next mains edge,
    // pulled forward by the trim; ticks restart from it each period
    wire virt_edge = (virt_cnt == 24'h00_0001);

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            since_edge <= 24'h00_0000;
            period <= NOM50;
            virt_cnt <= 24'h00_0000;
        end else begin
            if (edge_ok) begin
                since_edge <= 24'h00_0000;
                period <= new_period;
                virt_cnt <= lead_load;
            end else begin
                if (since_edge != 24'hff_ffff) begin
                    since_edge <= since_edge + 24'h00_0001;
                end
                // without edges the timers repeat the last period
                if (virt_edge) begin
                    virt_cnt <= period;
                end else if (virt_cnt != 24'h00_0000) begin
                    virt_cnt <= virt_cnt - 24'h00_0001;
                end
            end
        end
    end

    // tick generator: ticks per period = 48 << rate code
    wire [1:0] rate_sel = modem_config[`SFK_CFG_RATE_HI:`SFK_CFG_RATE_LO];
    wire [23:0] ticks_per_period = `SFK_BASE_TICKS << rate_sel;
    // the remainder is kept on wrap so tick spacing averages exactly
    reg [23:0] nco_acc;
    wire [24:0] nco_sum = {1'b0, nco_acc} + {1'b0, ticks_per_period};
    wire nco_wrap = nco_sum >= {1'b0, period};
    wire tick = virt_edge | nco_wrap;

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            nco_acc <= 24'h00_0000;
        end else if (virt_edge) begin
            nco_acc <= 24'h00_0000;
        end else if (nco_wrap) begin
            nco_acc <= nco_sum[23:0] - period;
        end else begin
            nco_acc <= nco_sum[23:0];
        end
    end

    // tick counter, independent of transmit/receive mode
    // reset parks the count on the last tick, so the first tick after
    // reset is a frame start and software sees a clean frame boundary
    reg [11:0] tick_count;
    wire [11:0] next_count = (tick_count == `SFK_LAST_TICK) ?
        12'h000 : tick_count + 12'h001;
    wire at_bit = (next_count[2:0] == 3'h0);
    wire at_byte = (next_count[5:0] == 6'h00);
    wire at_frame = (next_count == 12'h000);
    wire at_early_byte = (next_count[5:0] == `SFK_BYTE_EARLY_PHASE);
    wire at_early_frame = (next_count == `SFK_EARLY_FRAME_TICK);

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_count <= `SFK_LAST_TICK;
            chip_tick_o <= 1'b0;
            bit_strobe_o <= 1'b0;
            byte_strobe_o <= 1'b0;
            frame_strobe_o <= 1'b0;
            early_byte_strobe_o <= 1'b0;
            early_frame_strobe_o <= 1'b0;
            frame_lead_o <= 1'b0;
            sync_output_pin_o <= 1'b0;
        end else begin
            chip_tick_o <= tick;
            bit_strobe_o <= tick & at_bit;
            byte_strobe_o <= tick & at_byte;
            frame_strobe_o <= tick & at_frame;
            early_byte_strobe_o <= tick & at_early_byte;
            early_frame_strobe_o <= tick & at_early_frame;
            if (tick) begin
                tick_count <= next_count;
                if (at_early_frame) begin
                    frame_lead_o <= 1'b1;
                end else if (at_frame) begin
                    frame_lead_o <= 1'b0;
                end
            end
            // pin shows the lead window only while the select bit is low
            sync_output_pin_o <= ~modem_config[`SFK_CFG_SYNC_SEL_BIT] &
                frame_lead_o;
        end
    end

    // bit sequencer: byte taken at byte boundary, msb sent first
    // software must write the next byte before the byte strobe; the
    // early byte strobe gives it eight ticks of warning
    reg [7:0] tx_shift;
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_shift <= 8'h00;
        end else if (tick && at_byte) begin
            tx_shift <= transmit_byte;
        end else if (tick && at_bit) begin
            tx_shift <= {tx_shift[6:0], 1'b0};
        end
    end
    wire tx_bit = tx_shift[7];

    // synthesizer update rate: 3 MHz from 200 MHz by fractional divider
    // the rate is an average: single enables jitter by one clock,
    // far below what the tone frequencies can resolve
    reg [7:0] dds_frac;
    wire [8:0] frac_sum = {1'b0, dds_frac} + {1'b0, DDS_NUM};
    wire dds_en = (frac_sum >= {1'b0, DDS_DEN});
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dds_frac <= 8'h00;
        end else if (dds_en) begin
            dds_frac <= frac_sum[7:0] - DDS_DEN;
        end else begin
            dds_frac <= frac_sum[7:0];
        end
    end

    // phase accumulator
    // a new start always begins at phase zero, so the first sample is 0
    reg [17:0] phase_acc;
    reg dds_run;
    reg mode_q;
    wire [15:0] step = tx_bit ? mark_tone_step : space_tone_step;
    wire [18:0] phase_sum = {1'b0, phase_acc} + {3'b000, step};
    wire tx_start = transmit_mode_flag & ~mode_q;

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_acc <= STEP_ZERO;
            dds_run <= 1'b0;
            mode_q <= 1'b0;
            tx_active_o <= 1'b0;
        end else begin
            mode_q <= transmit_mode_flag;
            tx_active_o <= dds_run;
            if (tx_start) begin
                phase_acc <= STEP_ZERO;
                dds_run <= 1'b1;
            end else if (dds_run && dds_en) begin
                if (!transmit_mode_flag && phase_sum[18]) begin
                    // stop at the end of the sine period in progress
                    phase_acc <= STEP_ZERO;
                    dds_run <= 1'b0;
                end else begin
                    // step changes never reset phase
                    phase_acc <= phase_sum[17:0];
                end
            end
        end
    end

    wire signed [11:0] sine_sample;
    wire pdm_bit;

    sfk_sine_shaper u_sine (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .sample_en_i(dds_run),
        .phase_i(phase_acc[17:8]),
        .sample_o(sine_sample)
    );

    sfk_sigma_delta u_sd (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .sample_i(sine_sample),
        .pdm_o(pdm_bit)
    );

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pdm_o <= 1'b0;
        end else begin
            // idle output holds low instead of a 50% idle pattern
            pdm_o <= dds_run & pdm_bit;
        end
    end

    // register read port, data one cycle after the strobe
    // status is read only; a write to its address falls to the default
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            case (addr_i)
                `SFK_ADDR_CONFIG: rdata_o <= {24'h00_0000, modem_config};
                `SFK_ADDR_TRIM: rdata_o <= {24'h00_0000, zero_cross_phase_trim};
                `SFK_ADDR_TXBYTE: rdata_o <= {24'h00_0000, transmit_byte};
                `SFK_ADDR_MARK: rdata_o <= {16'h0000, mark_tone_step};
                `SFK_ADDR_SPACE: rdata_o <= {16'h0000, space_tone_step};
                `SFK_ADDR_CTRL: rdata_o <= {24'h00_0000, modem_ctrl};
                `SFK_ADDR_STATUS: rdata_o <= {16'h0000, dds_run,
                    frame_lead_o, zc_level, 1'b0, tick_count};
                default: rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end
endmodule // sfk_modem_core

// [design/sfk_regs.vh]
/*
 * Register offsets, field positions, reset values and timing counts of the
 * mains-synchronised tone modulator core.
 * Assumes a 200 MHz system clock and a word-aligned 8-bit register address.
 */
`ifndef SFK_REGS_VH
`define SFK_REGS_VH

// register byte addresses
`define SFK_ADDR_CONFIG 8'h00
`define SFK_ADDR_TRIM 8'h04
`define SFK_ADDR_TXBYTE 8'h08
`define SFK_ADDR_MARK 8'h0c
`define SFK_ADDR_SPACE 8'h10
`define SFK_ADDR_CTRL 8'h14
`define SFK_ADDR_STATUS 8'h18

// field positions
`define SFK_CFG_MAINS_BIT 0
`define SFK_CFG_RATE_LO 1
`define SFK_CFG_RATE_HI 2
`define SFK_CFG_SYNC_SEL_BIT 7
`define SFK_CTRL_TXMODE_BIT 0

// reset values
`define SFK_RST_CONFIG 8'h00
`define SFK_RST_TRIM 8'h00
`define SFK_RST_TXBYTE 8'h00
`define SFK_RST_STEP 16'h0000
`define SFK_RST_CTRL 8'h00

// tick frame layout
`define SFK_TICKS_PER_BIT 8
`define SFK_TICKS_PER_BYTE 64
`define SFK_LAST_TICK 12'hb3f
`define SFK_EARLY_FRAME_TICK 12'hb38
`define SFK_BYTE_EARLY_PHASE 6'h38
`define SFK_BASE_TICKS 24'h00_0030

// timing
`define SFK_CLK_NS 5
`define SFK_CLK_HZ 200000000
`define SFK_TRIM_STEP_US 13
`define SFK_TRIM_STEP_CYC ((`SFK_TRIM_STEP_US * 1000) / `SFK_CLK_NS)
`define SFK_DDS_HZ 3000000
`define SFK_DDS_NUM (`SFK_DDS_HZ / 1000000)
`define SFK_DDS_DEN (`SFK_CLK_HZ / 1000000)
`define SFK_NOM_PERIOD_50 4000000
`define SFK_NOM_PERIOD_60 3333333

`endif

// [design/sfk_sigma_delta.v]
/*
 * First-order sigma-delta modulator: signed 12-bit sample in, one-bit
 * pulse-density stream out, one output bit per clock.
 * Assumes the sample is held between updates; zero gives a 50% density.
 */
`timescale 1ns/1ps
module sfk_sigma_delta (
    input wire mclk_i,
    input wire rstn_i,
    input wire signed [11:0] sample_i,
    output reg pdm_o
);
    reg [11:0] acc;
    wire [11:0] biased = {~sample_i[11], sample_i[10:0]};
    wire [12:0] sum = {1'b0, acc} + {1'b0, biased};

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc <= 12'h000;
            pdm_o <= 1'b0;
        end else begin
            acc <= sum[11:0];
            pdm_o <= sum[12];
        end
    end
endmodule // sfk_sigma_delta

// [design/sfk_sine_shaper.v]
/*
 * Sine shaper: turns the top ten bits of a phase word into a signed
 * 12-bit sample by a parabolic half-wave approximation.
 * Assumes phase is stable while sample_en is high; output is registered.
 */
`timescale 1ns/1ps
module sfk_sine_shaper (
    input wire mclk_i,
    input wire rstn_i,
    input wire sample_en_i,
    input wire [9:0] phase_i,
    output reg signed [11:0] sample_o
);
    wire [8:0] x = phase_i[8:0];
    wire [9:0] x_rem = 10'h200 - {1'b0, x};
    wire [18:0] prod = x * x_rem;
    // peak of x*(512-x) is 65536, >>5 gives 2048 which is clamped
    wire [13:0] mag_raw = prod[18:5];
    wire [10:0] mag = (mag_raw > 14'h07ff) ? 11'h7ff : mag_raw[10:0];

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sample_o <= 12'h000;
        end else if (!sample_en_i) begin
            sample_o <= 12'h000;
        end else if (phase_i[9]) begin
            sample_o <= -$signed({1'b0, mag});
        end else begin
            sample_o <= $signed({1'b0, mag});
        end
    end
endmodule // sfk_sine_shaper

// [dv/sfk_core_props.sv]
/*
 * Checker for the modem core: strobe pattern against a reference tick
 * count, frame lead and sync pin, idle output, read data clearing.
 * Assumes it is bound to sfk_modem_core and sees only its ports.
 */
`timescale 1ns/1ps
module sfk_core_props (
    input wire mclk_i,
    input wire rstn_i,
    input wire rd_i,
    input wire [31:0] rdata_o,
    input wire chip_tick_o,
    input wire bit_strobe_o,
    input wire byte_strobe_o,
    input wire frame_strobe_o,
    input wire early_byte_strobe_o,
    input wire early_frame_strobe_o,
    input wire frame_lead_o,
    input wire sync_output_pin_o,
    input wire tx_active_o,
    input wire pdm_o
);
    // reference count, aligned once at the first frame strobe seen
    reg [11:0] tc;
    reg fseen;
    wire [11:0] nx = (tc == 12'hb3f) ? 12'h000 : tc + 12'h001;
    wire tk = chip_tick_o && fseen;
    wire any_strobe = bit_strobe_o | byte_strobe_o | frame_strobe_o |
        early_byte_strobe_o | early_frame_strobe_o;
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tc <= 12'h000;
            fseen <= 1'b0;
        end else if (chip_tick_o) begin
            tc <= fseen ? nx : 12'h000;
            fseen <= fseen | frame_strobe_o;
        end
    end
    default clocking dcb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);
    a_strobe_on_tick: assert property (any_strobe |-> chip_tick_o)
        else $error("strobe outside a tick");
    a_bit_phase: assert property (tk |-> bit_strobe_o == (nx[2:0] == 3'h0))
        else $error("bit strobe off grid");
    a_byte_phase: assert property (tk |-> byte_strobe_o == (nx[5:0] == 6'h00))
        else $error("byte strobe off grid");
    a_frame_wrap: assert property (tk |-> frame_strobe_o == (nx == 12'h000))
        else $error("frame strobe off grid");
    a_early_byte: assert property (tk |-> early_byte_strobe_o == (nx[5:0] == 6'h38))
        else $error("early byte strobe off grid");
    a_early_frame: assert property (tk |-> early_frame_strobe_o == (nx == 12'hb38))
        else $error("early frame strobe off grid");
    a_lead_rise: assert property (early_frame_strobe_o |=> frame_lead_o)
        else $error("frame lead not raised");
    a_lead_fall: assert property (frame_strobe_o |=> !frame_lead_o)
        else $error("frame lead not dropped");
    a_sync_follows: assert property (sync_output_pin_o |-> $past(frame_lead_o))
        else $error("sync pin without frame lead");
    a_idle_quiet: assert property ((!tx_active_o) [*6] |-> !pdm_o)
        else $error("pulse stream while idle");
    a_read_clear: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
        else $error("read data outside read cycle");
    cover property (frame_strobe_o);
    cover property ($rose(tx_active_o));
    cover property (sync_output_pin_o);
endmodule // sfk_core_props

bind sfk_modem_core sfk_core_props props_u (
    .mclk_i, .rstn_i, .rd_i, .rdata_o, .chip_tick_o, .bit_strobe_o,
    .byte_strobe_o, .frame_strobe_o, .early_byte_strobe_o,
    .early_frame_strobe_o, .frame_lead_o, .sync_output_pin_o,
    .tx_active_o, .pdm_o
);

// [dv/sfk_mains_model.sv]
/*
 * Mains comparator model: square wave of a set period in clock cycles,
 * high for the first half of each period.
 * Assumes the period is at least two cycles; stopped means held low.
 */
`timescale 1ns/1ps
module sfk_mains_model (
    input wire mclk_i,
    input wire run_i,
    input wire [31:0] period_i,
    output reg level_o
);
    reg [31:0] cnt;
    initial begin
        cnt = 32'h0000_0000;
        level_o = 1'b0;
    end
    // a stopped comparator shows no edges at all, so the loop must coast
    always @(posedge mclk_i) begin
        if (!run_i) begin
            cnt <= 32'h0000_0000;
            level_o <= 1'b0;
        end else begin
            cnt <= (cnt + 32'h0000_0001 >= period_i) ? 32'h0000_0000
                : cnt + 32'h0000_0001;
            level_o <= (cnt < (period_i >> 1));
        end
    end
endmodule // sfk_mains_model

// [dv/testbench.sv]
/*
 * Self-checking bench for the modem core: register port, strobe counts
 * over a frame, rate codes, coasting without mains edges, tone bursts.
 * Assumes small nominal periods and the mains model at the same period.
 */
`timescale 1ns/1ps
`include "sfk_regs.vh"
module testbench;
    localparam integer PERIOD = 4000;
    reg mclk_i = 1'b0;
    reg rstn_i = 1'b0;
    reg [7:0] addr_i = 8'h00;
    reg [31:0] wdata_i = 32'h0000_0000;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg mains_run = 1'b1;
    wire [31:0] rdata_o;
    wire mains_sense_pin_i, chip_tick_o, bit_strobe_o, byte_strobe_o;
    wire frame_strobe_o, early_byte_strobe_o, early_frame_strobe_o;
    wire frame_lead_o, sync_output_pin_o, tx_active_o, pdm_o;
    wire [5:0] ev = {sync_output_pin_o, early_frame_strobe_o,
        early_byte_strobe_o, byte_strobe_o, bit_strobe_o, chip_tick_o};
    integer failures = 0;
    integer num_checks = 0;
    integer cycles = 0;

    always #2.5 mclk_i = ~mclk_i;

    sfk_mains_model mains_u (.mclk_i(mclk_i), .run_i(mains_run),
        .period_i(PERIOD), .level_o(mains_sense_pin_i));

    sfk_modem_core #(.NOM_PERIOD_50(4000), .NOM_PERIOD_60(3333)) dut_u (
        .mclk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .mains_sense_pin_i, .chip_tick_o, .bit_strobe_o, .byte_strobe_o,
        .frame_strobe_o, .early_byte_strobe_o, .early_frame_strobe_o,
        .frame_lead_o, .sync_output_pin_o, .tx_active_o, .pdm_o
    );

    function integer hi(input s);
        hi = (s === 1'b1);
    endfunction

    task print_verdict;
        begin
            if (failures == 0 && num_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    task check(input [31:0] exp, input [31:0] got, input [63:0] what);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("FAIL %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask

    task check_range(input integer lo, input integer hi_lim,
        input integer got, input [63:0] what);
        begin
            num_checks = num_checks + 1;
            if (got < lo || got > hi_lim) begin
                failures = failures + 1;
                $display("FAIL %0s expected %0d..%0d seen %0d", what, lo,
                    hi_lim, got);
            end
        end
    endtask

    task reg_wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge mclk_i);
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge mclk_i);
            wr_i <= 1'b0;
        end
    endtask

    task reg_rd(input [7:0] a, input [31:0] exp, input [63:0] what);
        begin
            @(posedge mclk_i);
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge mclk_i);
            rd_i <= 1'b0;
            #1;
            check(exp, rdata_o, what);
        end
    endtask

    task count_ticks(input integer len, output integer k);
        begin
            k = 0;
            repeat (len) begin
                @(posedge mclk_i);
                #1;
                k = k + hi(chip_tick_o);
            end
        end
    endtask

    task t_regs;
        reg [7:0] a;
        begin
            a = 8'h00;
            repeat (6) begin
                reg_rd(a, 32'h0000_0000, "reset");
                a = a + 8'h04;
            end
            reg_wr(8'h1c, 32'h0000_00ff);
            reg_rd(8'h1c, 32'h0000_0000, "unmapped");
            reg_wr(`SFK_ADDR_TRIM, 32'h0000_0001);
            reg_rd(`SFK_ADDR_TRIM, 32'h0000_0001, "trim");
            reg_wr(`SFK_ADDR_MARK, 32'hffff_1234);
            reg_rd(`SFK_ADDR_MARK, 32'h0000_1234, "mark");
            reg_wr(`SFK_ADDR_TXBYTE, 32'h0000_01a5);
            reg_rd(`SFK_ADDR_TXBYTE, 32'h0000_00a5, "txbyte");
            reg_wr(`SFK_ADDR_TRIM, 32'h0000_0000);
            reg_wr(`SFK_ADDR_TXBYTE, 32'h0000_0000);
            reg_wr(`SFK_ADDR_CONFIG, 32'h0000_0006);
            reg_rd(`SFK_ADDR_CONFIG, 32'h0000_0006, "config");
        end
    endtask

    task t_frame;
        integer n, j;
        integer c [0:5];
        begin
            n = 0;
            while (frame_strobe_o !== 1'b1 && n < 35000) begin
                @(posedge mclk_i);
                #1;
                n = n + 1;
            end
            for (j = 0; j < 6; j = j + 1)
                c[j] = 0;
            do begin
                for (j = 0; j < 6; j = j + 1)
                    c[j] = c[j] + hi(ev[j]);
                @(posedge mclk_i);
                #1;
                n = n + 1;
            end while (frame_strobe_o !== 1'b1 && n < 70000);
            check_range(2880, 2880, c[0], "ticks");
            check_range(360, 360, c[1], "bits");
            check_range(45, 45, c[2], "bytes");
            check_range(45, 45, c[3], "ebytes");
            check_range(1, 1, c[4], "eframes");
            check_range(60, 100, c[5], "sync");
        end
    endtask

    task t_rates;
        integer i, k;
        reg [1:0] r;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                r = i;
                // 60 Hz bit rides along on odd codes
                reg_wr(`SFK_ADDR_CONFIG, {29'h0000_0000, r, r[0]});
                repeat (1000) @(posedge mclk_i);
                count_ticks(PERIOD, k);
                check_range((48 << i) - 2, (48 << i) + 2, k, "rate");
            end
        end
    endtask

    task t_hold;
        integer k;
        begin
            reg_wr(`SFK_ADDR_CONFIG, 32'h0000_0006);
            repeat (PERIOD) @(posedge mclk_i);
            mains_run <= 1'b0;
            repeat (PERIOD) @(posedge mclk_i);
            count_ticks(PERIOD, k);
            check_range(382, 386, k, "coast");
            mains_run <= 1'b1;
        end
    endtask

    task t_tx(input [15:0] step, input integer lo, input integer hi_lim);
        integer n, ones;
        begin
            reg_wr(`SFK_ADDR_MARK, 32'h0000_0800);
            reg_wr(`SFK_ADDR_SPACE, {16'h0000, step});
            #1;
            check(32'h0000_0000, {30'h0000_0000, tx_active_o, pdm_o}, "idle");
            reg_wr(`SFK_ADDR_CTRL, 32'h0000_0001);
            reg_wr(`SFK_ADDR_CTRL, 32'h0000_0000);
            #1;
            check(32'h0000_0001, {31'h0000_0000, tx_active_o}, "start");
            n = 0;
            ones = 0;
            // burst must run on to the end of the sine period in progress
            while (tx_active_o === 1'b1 && n < 6000) begin
                @(posedge mclk_i);
                #1;
                n = n + 1;
                ones = ones + hi(pdm_o);
            end
            check_range(lo, hi_lim, n, "burst");
            check_range(n * 3 / 10, n * 7 / 10, ones, "density");
        end
    endtask

    always @(posedge mclk_i) begin
        cycles = cycles + 1;
        if (cycles == 110000) begin
            failures = failures + 1;
            print_verdict;
        end
    end

    initial begin
        repeat (4) @(posedge mclk_i);
        rstn_i <= 1'b1;
        t_regs;
        t_frame;
        t_rates;
        t_hold;
        t_tx(16'h2000, 2080, 2220);
        t_tx(16'h1000, 4200, 4350);
        print_verdict;
    end
endmodule // testbench
